//--- core/abd_addr_bridge.sv
/*
  Address buffer, steering and decode for the CPU, X, system and memory
  address buses, high and low halves in one block.
  Assumes every pin input is asynchronous to sys_clk_in; outside logic
  resolves bus wires from the output enables.
*/
`timescale 1ns/10ps
module abd_addr_bridge
  import abd_pkg::*;
#(
  parameter int REF_W = REF_W_DEF
)
(
  input  wire logic              sys_clk_in,
  input  wire logic              rst_n_in,
  input  wire logic [ADDR_W-1:0] cpu_addr_in,
  output logic      [ADDR_W-1:0] cpu_addr_out,
  output logic      [ADDR_W-1:0] cpu_addr_oe_out,
  input  wire logic [ADDR_W-1:0] x_addr_bus_in,
  output logic      [ADDR_W-1:0] x_addr_bus_out,
  output logic      [ADDR_W-1:0] x_addr_bus_oe_out,
  input  wire logic [ADDR_W-1:0] sys_addr_in,
  output logic      [ADDR_W-1:0] sys_addr_out,
  output logic      [ADDR_W-1:0] sys_addr_oe_out,
  output logic      [ADDR_W-1:0] mem_addr_bus_out,
  input  wire logic              dma_hold_ack_in,
  input  wire logic              ext_master_in,
  input  wire logic              refresh_in,
  input  wire logic              at_bus_cycle_en_in,
  input  wire logic              mem_addr_latch_en_in,
  input  wire logic              xbus_ext_enable_n_in,
  input  wire logic              sysbus_ext_enable_n_in,
  input  wire logic              ext_decode_n_in,
  output abd_region_type         region_out,
  output abd_cs_type             cs_out
);

  localparam int SYNC_W = 3 * ADDR_W + CTRL_W;

  logic [SYNC_W-1:0] meta_q;
  logic [SYNC_W-1:0] sync_q;
  logic [SYNC_W-1:0] raw;
  logic [ADDR_W-1:0] cpu_s;
  logic [ADDR_W-1:0] x_s;
  logic [ADDR_W-1:0] sys_s;
  logic              dma_s;
  logic              master_s;
  logic              ref_s;
  logic              at_bus_cycle_en_s;
  logic              mem_addr_latch_en_s;
  logic              xext_n_s;
  logic              sext_n_s;
  logic              ext_decode_n_n_s;

  assign raw = {cpu_addr_in, x_addr_bus_in, sys_addr_in,
                dma_hold_ack_in, ext_master_in, refresh_in,
                at_bus_cycle_en_in, mem_addr_latch_en_in,
                xbus_ext_enable_n_in, sysbus_ext_enable_n_in,
                ext_decode_n_in};

  // two-flop synchroniser per pin bit
  for (genvar i = 0; i < SYNC_W; i++) begin : g_sync
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        meta_q[i] <= 1'b0;
        sync_q[i] <= 1'b0;
      end else begin
        meta_q[i] <= raw[i];
        sync_q[i] <= meta_q[i];
      end
    end
  end

  assign {cpu_s, x_s, sys_s, dma_s, master_s, ref_s, at_bus_cycle_en_s, mem_addr_latch_en_s,
          xext_n_s, sext_n_s, ext_decode_n_n_s} = sync_q;

  // latch and refresh state
  logic              mem_addr_latch_en_prev_q;
  logic              ref_prev_q;
  logic [ADDR_W-1:0] cpu_lat_q;
  logic [ADDR_W-1:0] cpu_lat_d;
  logic              lio_lat_q;
  logic              lio_lat_d;
  logic              lmeg_lat_q;
  logic              lmeg_lat_d;
  logic [REF_W-1:0]  ref_cnt_q;
  logic [REF_W-1:0]  ref_cnt_d;
  logic              mem_addr_latch_en_fall;
  logic              ref_fall;

  always_comb begin
    mem_addr_latch_en_fall  = mem_addr_latch_en_prev_q & ~mem_addr_latch_en_s;
    ref_fall   = ref_prev_q & ~ref_s;
    cpu_lat_d  = cpu_lat_q;
    lio_lat_d  = lio_lat_q;
    lmeg_lat_d = lmeg_lat_q;
    ref_cnt_d  = ref_cnt_q;
    if (mem_addr_latch_en_fall) begin
      cpu_lat_d  = cpu_s;
      lio_lat_d  = ~dma_s & (cpu_s[LIO_MSB:LIO_LSB] == 4'h0);
      lmeg_lat_d = ~dma_s & (cpu_s[ADDR_W-1:LMEG_LSB] == 12'h000);
    end
    // advance row address after each refresh
    if (ref_fall) begin
      ref_cnt_d = REF_W'(ref_cnt_q + 1'b1);
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mem_addr_latch_en_prev_q <= 1'b0;
      ref_prev_q  <= 1'b0;
      cpu_lat_q   <= '0;
      lio_lat_q   <= 1'b0;
      lmeg_lat_q  <= 1'b0;
      ref_cnt_q   <= '0;
    end else begin
      mem_addr_latch_en_prev_q <= mem_addr_latch_en_s;
      ref_prev_q  <= ref_s;
      cpu_lat_q   <= cpu_lat_d;
      lio_lat_q   <= lio_lat_d;
      lmeg_lat_q  <= lmeg_lat_d;
      ref_cnt_q   <= ref_cnt_d;
    end
  end

  // steering and decode
  abd_mode_type      mode;
  logic [ADDR_W-1:0] cpu_d;
  logic [ADDR_W-1:0] cpu_oe_d;
  logic [ADDR_W-1:0] x_d;
  logic [ADDR_W-1:0] x_oe_d;
  logic [ADDR_W-1:0] sys_d;
  logic [ADDR_W-1:0] sys_oe_d;
  logic [ADDR_W-1:0] mem_d;
  logic [LOW_W-1:0]  dec_addr;
  logic              lio_g;
  abd_region_type    region_d;
  abd_cs_type        cs_d;

  always_comb begin
    // one source per bus except sys bits 1:0 in AT mode, fixed priority
    if (dma_s) begin
      mode = MODE_DMA;
    end else if (master_s) begin
      mode = MODE_MASTER;
    end else if (ref_s) begin
      mode = MODE_REFRESH;
    end else if (at_bus_cycle_en_s) begin
      mode = MODE_AT;
    end else begin
      mode = MODE_CPU;
    end
    cpu_d    = '0;
    cpu_oe_d = '0;
    x_d      = '0;
    x_oe_d   = '0;
    sys_d    = '0;
    sys_oe_d = '0;
    mem_d    = cpu_lat_q;
    dec_addr = cpu_lat_q[LOW_W-1:0];
    // full-width buffers, high and low halves
    case (mode)
      MODE_DMA: begin
        cpu_d    = x_s;
        cpu_oe_d = '1;
        sys_d    = x_s;
        sys_oe_d = '1;
        mem_d    = x_s;
        dec_addr = x_s[LOW_W-1:0];
      end
      MODE_MASTER: begin
        cpu_d    = sys_s;
        cpu_oe_d = '1;
        x_d      = sys_s;
        x_oe_d   = '1;
        mem_d    = sys_s;
        dec_addr = sys_s[LOW_W-1:0];
      end
      MODE_REFRESH: begin
        // counter as row address, rest low
        sys_d    = ADDR_W'(ref_cnt_q);
        sys_oe_d = '1;
        mem_d    = mem_addr_bus_out;
      end
      MODE_AT: begin
        x_d      = cpu_lat_q;
        x_oe_d   = '1;
        sys_d    = cpu_lat_q;
        sys_oe_d = '1;
        mem_d    = cpu_lat_q;
        // low pair from x bus, memory keeps bits 3:0
        x_oe_d[AT_XS_MSB:0]   = '0;
        sys_d[AT_XS_MSB:0]    = x_s[AT_XS_MSB:0];
        mem_d[AT_MA_LSB-1:0]  = mem_addr_bus_out[AT_MA_LSB-1:0];
      end
      default: begin
        mem_d = cpu_lat_q;
      end
    endcase
    // unextended buses force bits 27:24 low
    if (xext_n_s) begin
      x_d[EXT_MSB:EXT_LSB] = '0;
    end
    if (sext_n_s) begin
      sys_d[EXT_MSB:EXT_LSB] = '0;
    end
    lio_g = lio_lat_q & ~dma_s;
    region_d.local_io_space_sel = lio_g;
    region_d.low_meg_sel        = lmeg_lat_q & ~dma_s;
    region_d.below_64mb     = cpu_s[ADDR_W-1:REGION_LSB] == 6'h00;
    region_d.top_rom_region = cpu_s[ADDR_W-1:REGION_LSB] == TOP_ROM_CODE;
  end

  abd_low_decode u_low_decode (
    .addr_in         (dec_addr),
    .lio_sel_in      (lio_g),
    .ext_decode_n_in (ext_decode_n_n_s),
    .cs_out          (cs_d)
  );

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cpu_addr_out      <= '0;
      cpu_addr_oe_out   <= '0;
      x_addr_bus_out    <= '0;
      x_addr_bus_oe_out <= '0;
      sys_addr_out      <= '0;
      sys_addr_oe_out   <= '0;
      mem_addr_bus_out  <= '0;
      region_out        <= '0;
      cs_out            <= '0;
    end else begin
      cpu_addr_out      <= cpu_d;
      cpu_addr_oe_out   <= cpu_oe_d;
      x_addr_bus_out    <= x_d;
      x_addr_bus_oe_out <= x_oe_d;
      sys_addr_out      <= sys_d;
      sys_addr_oe_out   <= sys_oe_d;
      mem_addr_bus_out  <= mem_d;
      region_out        <= region_d;
      cs_out            <= cs_d;
    end
  end

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_io_latch;
    mem_addr_latch_en_fall && !dma_s && cpu_s[LIO_MSB:LIO_LSB] == 4'h0 ##1 !dma_s;
  endsequence

  chk_io_latch_set: assert property (
    s_io_latch |=> region_out.local_io_space_sel)
    else $error("io select not latched on mem_addr_latch_en fall");

  chk_meg_latch_clr: assert property (
    mem_addr_latch_en_fall && cpu_s[ADDR_W-1:LMEG_LSB] != 12'h000 ##1 1'b1
      |=> !region_out.low_meg_sel)
    else $error("low meg select set for high address");

  chk_rom_region: assert property (
    cpu_s[ADDR_W-1:REGION_LSB] == 6'h3f
      |=> region_out.top_rom_region && !region_out.below_64mb)
    else $error("top rom region decode wrong");

  chk_cpu_latch: assert property (
    mem_addr_latch_en_fall |=> cpu_lat_q == $past(cpu_s) ##1 mem_addr_bus_out ==
      $past(cpu_lat_q) || $past(dma_s || master_s || ref_s || at_bus_cycle_en_s))
    else $error("cpu address not latched or routed");

  chk_dma_route: assert property (
    dma_s |=> cpu_addr_out == $past(x_s) && mem_addr_bus_out ==
      $past(x_s) && x_addr_bus_oe_out == '0)
    else $error("dma routing wrong");

  chk_master_route: assert property (
    master_s && !dma_s |=> cpu_addr_out == $past(sys_s) &&
      sys_addr_oe_out == '0)
    else $error("master routing wrong");

  chk_refresh_addr: assert property (
    ref_s && !dma_s && !master_s |=> sys_addr_oe_out == '1 &&
      sys_addr_out == ADDR_W'($past(ref_cnt_q)))
    else $error("refresh row address wrong");

  chk_refresh_count: assert property (
    ref_fall |=> ref_cnt_q == REF_W'($past(ref_cnt_q) + 1'b1))
    else $error("refresh counter did not advance");

  chk_at_low_route: assert property (
    at_bus_cycle_en_s && !dma_s && !master_s && !ref_s |=>
      sys_addr_out[1:0] == $past(x_s[1:0]) &&
      x_addr_bus_oe_out[1:0] == 2'b00)
    else $error("at cycle low routing wrong");

  chk_ext_mask: assert property (
    xext_n_s && sext_n_s |=> x_addr_bus_out[EXT_MSB:EXT_LSB] == 4'h0 &&
      sys_addr_out[EXT_MSB:EXT_LSB] == 4'h0)
    else $error("extension bits not forced low");

  chk_cs_qual: assert property (
    ext_decode_n_n_s && !lio_g |=> cs_out == '0)
    else $error("chip select without io qualifier");

  chk_nmi_decode: assert property (
    ext_decode_n_n_s && lio_g && dec_addr == 12'h070 |=> cs_out.nmi_mask_port_sel)
    else $error("nmi port decode missed");

  chk_reloc_decode: assert property (
    !ext_decode_n_n_s && dec_addr[9:0] == 10'h061 |=> cs_out.sys_ctrl_port_sel)
    else $error("relocated decode missed");

endmodule

//--- core/abd_low_decode.sv
/*
  Peripheral chip-select decode of the low address half.
  Assumes address and qualifiers are already synchronous to the clock;
  the result is combinational and registered by the caller.
*/
`timescale 1ns/10ps
module abd_low_decode
  import abd_pkg::*;
(
  input  wire logic [LOW_W-1:0] addr_in,
  input  wire logic             lio_sel_in,
  input  wire logic             ext_decode_n_in,
  output abd_cs_type            cs_out
);

  logic [LOW_W-1:0] care;
  logic             qual;

  function automatic logic addr_hit(input logic [LOW_W-1:0] a,
                                    input logic [LOW_W-1:0] ref_a,
                                    input logic [LOW_W-1:0] mask);
    return ((a ^ ref_a) & mask) == 12'h000;
  endfunction

  always_comb begin
    // relocation ignores qualifier and top bits
    care = ext_decode_n_in ? FULL_CARE : RELOC_CARE;
    qual = ext_decode_n_in ? lio_sel_in : 1'b1;
    cs_out.cfg_index_port_sel = qual &
      (addr_hit(addr_in, CFG_INDEX_A, care) |
       addr_hit(addr_in, CFG_DATA_A, care));
    cs_out.kbd_ctrl_sel = qual &
      (addr_hit(addr_in, KBD_DATA_A, care) |
       addr_hit(addr_in, KBD_CMD_A, care));
    cs_out.sys_ctrl_port_sel = qual & addr_hit(addr_in, SYS_CTRL_A, care);
    cs_out.nmi_mask_port_sel = qual & addr_hit(addr_in, NMI_MASK_A, care);
    cs_out.math_coproc_sel = qual &
      addr_hit(addr_in, COPROC_BASE_A, care & COPROC_CARE);
  end

endmodule

//--- core/abd_pkg.sv
/*
  Shared constants and types of the address buffer and decode block.
  Assumes a 32-bit CPU address, a 12-bit low half and a 20-bit high half.
*/
package abd_pkg;

  localparam int          ADDR_W        = 32;
  localparam int          LOW_W         = 12;
  localparam int          LIO_MSB       = 15;
  localparam int          LIO_LSB       = 12;
  localparam int          LMEG_LSB      = 20;
  localparam int          REGION_LSB    = 26;
  localparam int          EXT_LSB       = 24;
  localparam int          EXT_MSB       = 27;
  localparam int          AT_MA_LSB     = 4;
  localparam int          AT_XS_MSB     = 1;
  localparam logic [5:0]  TOP_ROM_CODE  = 6'h3f;
  localparam logic [11:0] CFG_INDEX_A   = 12'h022;
  localparam logic [11:0] CFG_DATA_A    = 12'h023;
  localparam logic [11:0] KBD_DATA_A    = 12'h060;
  localparam logic [11:0] KBD_CMD_A     = 12'h064;
  localparam logic [11:0] SYS_CTRL_A    = 12'h061;
  localparam logic [11:0] NMI_MASK_A    = 12'h070;
  localparam logic [11:0] COPROC_BASE_A = 12'h0e0;
  localparam logic [11:0] COPROC_CARE   = 12'hfe0;
  localparam logic [11:0] FULL_CARE     = 12'hfff;
  localparam logic [11:0] RELOC_CARE    = 12'h3ff;
  localparam int          REF_W_DEF     = 9;
  localparam int          CTRL_W        = 8;

  typedef enum logic [2:0] {
    MODE_CPU,
    MODE_DMA,
    MODE_MASTER,
    MODE_REFRESH,
    MODE_AT
  } abd_mode_type;

  typedef struct packed {
    logic local_io_space_sel;
    logic low_meg_sel;
    logic below_64mb;
    logic top_rom_region;
  } abd_region_type;

  typedef struct packed {
    logic cfg_index_port_sel;
    logic kbd_ctrl_sel;
    logic sys_ctrl_port_sel;
    logic nmi_mask_port_sel;
    logic math_coproc_sel;
  } abd_cs_type;

endpackage

//--- testbench/abd_far_side.sv
/*
  Far side of the address bridge: CPU, X bus and system bus owners and
  the board straps of the extension enables.
  Assumes a bus owner drives every bit the bridge leaves undriven.
*/
`timescale 1ns/10ps
module abd_far_side
  import abd_pkg::*;
(
  input  wire logic [ADDR_W-1:0] cpu_drv_in,
  input  wire logic [ADDR_W-1:0] x_drv_in,
  input  wire logic [ADDR_W-1:0] sys_drv_in,
  input  wire logic [ADDR_W-1:0] cpu_out_in,
  input  wire logic [ADDR_W-1:0] cpu_oe_in,
  input  wire logic [ADDR_W-1:0] x_out_in,
  input  wire logic [ADDR_W-1:0] x_oe_in,
  input  wire logic [ADDR_W-1:0] sys_out_in,
  input  wire logic [ADDR_W-1:0] sys_oe_in,
  input  wire logic              x_gnd_in,
  input  wire logic              sys_gnd_in,
  output logic      [ADDR_W-1:0] cpu_bus_out,
  output logic      [ADDR_W-1:0] x_bus_out,
  output logic      [ADDR_W-1:0] sys_bus_out,
  output logic                   x_ext_n_out,
  output logic                   sys_ext_n_out
);
  // wired buses: bridge owns the bits it enables
  assign cpu_bus_out = (cpu_out_in & cpu_oe_in) | (cpu_drv_in & ~cpu_oe_in);
  assign x_bus_out   = (x_out_in & x_oe_in) | (x_drv_in & ~x_oe_in);
  assign sys_bus_out = (sys_out_in & sys_oe_in) | (sys_drv_in & ~sys_oe_in);
  assign x_ext_n_out   = ~x_gnd_in;
  assign sys_ext_n_out = ~sys_gnd_in;
endmodule

//--- testbench/address_buffer_decode_test.sv
/*
  Self-checking bench of the address bridge, with queued expectations.
  Assumes the far side model resolves the shared address buses.
*/
`timescale 1ns/10ps
module address_buffer_decode_test;
  import abd_pkg::*;
  typedef struct {int k; logic [31:0] m; logic [31:0] e;} abd_note_type;
  logic        clk, rst_n, dma, mst, rf, at, mem_addr_latch_en, xg, sg, exd_n;
  logic [31:0] cpu_drv, x_drv, sys_drv, a, v;
  logic [31:0] cpu_b, x_b, sys_b, cpu_o, cpu_oe, x_o, x_oe, sys_o, sys_oe;
  logic [31:0] mem_o;
  logic        xe_n, se_n;
  abd_region_type reg_o;
  abd_cs_type     cs_o;
  abd_note_type   notes[$];
  int             bad_count, n_compared;
  event           look;
  string nm[9] = '{"mem","cpu","x","sys","region","cs","cpu_oe","x_oe",
                   "sys_oe"};
  logic [31:0] tab[12] = '{32'h22, 32'h23, 32'h60, 32'h64, 32'h61, 32'h70,
    32'he0, 32'hff, 32'hdf, 32'h165, 32'h1060, 32'hfc000064};

  abd_addr_bridge abd_addr_bridge_inst (
    .sys_clk_in(clk), .rst_n_in(rst_n), .cpu_addr_in(cpu_b),
    .cpu_addr_out(cpu_o), .cpu_addr_oe_out(cpu_oe), .x_addr_bus_in(x_b),
    .x_addr_bus_out(x_o), .x_addr_bus_oe_out(x_oe), .sys_addr_in(sys_b),
    .sys_addr_out(sys_o), .sys_addr_oe_out(sys_oe), .mem_addr_bus_out(mem_o),
    .dma_hold_ack_in(dma), .ext_master_in(mst), .refresh_in(rf),
    .at_bus_cycle_en_in(at), .mem_addr_latch_en_in(mem_addr_latch_en),
    .xbus_ext_enable_n_in(xe_n), .sysbus_ext_enable_n_in(se_n),
    .ext_decode_n_in(exd_n), .region_out(reg_o), .cs_out(cs_o));

  abd_far_side abd_far_side_inst (
    .cpu_drv_in(cpu_drv), .x_drv_in(x_drv), .sys_drv_in(sys_drv),
    .cpu_out_in(cpu_o), .cpu_oe_in(cpu_oe), .x_out_in(x_o), .x_oe_in(x_oe),
    .sys_out_in(sys_o), .sys_oe_in(sys_oe), .x_gnd_in(xg), .sys_gnd_in(sg),
    .cpu_bus_out(cpu_b), .x_bus_out(x_b), .sys_bus_out(sys_b),
    .x_ext_n_out(xe_n), .sys_ext_n_out(se_n));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  function automatic logic [31:0] pick(int k);
    case (k)
      0: return mem_o;
      1: return cpu_o;
      2: return x_o;
      3: return sys_o;
      4: return 32'(reg_o);
      5: return 32'(cs_o);
      6: return cpu_oe;
      7: return x_oe;
      default: return sys_oe;
    endcase
  endfunction

  function automatic logic hit(logic [11:0] a, logic [11:0] r,
                               logic [11:0] c);
    return (a & c) == (r & c);
  endfunction

  function automatic abd_cs_type cs_exp(logic [11:0] a, logic q, logic rel);
    logic [11:0] c;
    abd_cs_type  s;
    c = rel ? RELOC_CARE : FULL_CARE;
    q = q | rel;
    s.cfg_index_port_sel = q &
      (hit(a, CFG_INDEX_A, c) | hit(a, CFG_DATA_A, c));
    s.kbd_ctrl_sel = q & (hit(a, KBD_DATA_A, c) | hit(a, KBD_CMD_A, c));
    s.sys_ctrl_port_sel = q & hit(a, SYS_CTRL_A, c);
    s.nmi_mask_port_sel = q & hit(a, NMI_MASK_A, c);
    s.math_coproc_sel = q & hit(a, COPROC_BASE_A, c & COPROC_CARE);
    return s;
  endfunction

  task automatic note(int k, logic [31:0] m, logic [31:0] e);
    abd_note_type n;
    n.k = k;
    n.m = m;
    n.e = e;
    notes.push_back(n);
  endtask

  task automatic tick(int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic settle;
    tick(6);
    #1;
    -> look;
    #1;
    @(posedge clk);
  endtask

  task automatic cpu_cycle(logic [31:0] a, logic rel);
    logic io;
    io = (a[15:12] == 4'h0);
    cpu_drv <= a;
    mem_addr_latch_en <= 1'b1;
    tick(3);
    mem_addr_latch_en <= 1'b0;
    note(0, '1, a);
    note(4, 32'hf, 32'({io, a[31:20] == 12'h000, a[31:26] == 6'h00,
      a[31:26] == 6'h3f}));
    note(5, 32'h1f, 32'(cs_exp(a[11:0], io, rel)));
    settle();
  endtask

  initial begin
    abd_note_type n;
    forever begin
      @(look);
      while (notes.size() > 0) begin
        n = notes.pop_front();
        n_compared++;
        if ((pick(n.k) & n.m) !== (n.e & n.m)) begin
          bad_count++;
          $display("MISMATCH %s expected %h seen %h", nm[n.k], n.e & n.m,
                   pick(n.k) & n.m);
        end
      end
    end
  end

  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial begin
    tick(3000);
    bad_count++;
    $display("watchdog expired");
    summarize();
  end

  initial begin
    {rst_n, dma, mst, rf, at, mem_addr_latch_en, exd_n} = 7'h01;
    {xg, sg} = 2'b11;
    {cpu_drv, x_drv, sys_drv} = '0;
    void'($urandom(52993));
    tick(8);
    rst_n <= 1'b1;
    tick(4);
    for (int i = 0; i < 3; i++) begin
      rf <= 1'b1;
      at <= (i == 2);
      note(3, '1, 32'(i));
      note(8, '1, '1);
      settle();
      {rf, at} <= 2'b00;
      tick(4);
    end
    $display("refresh test done");
    for (int i = 0; i < 16; i++) begin
      a = (i < 12) ? tab[i] : $urandom();
      cpu_cycle(a, 1'b0);
    end
    exd_n <= 1'b0;
    cpu_cycle(32'h460, 1'b1);
    cpu_cycle(32'h5070, 1'b1);
    exd_n <= 1'b1;
    $display("decode test done");
    for (int g = 0; g < 2; g++) begin
      v = $urandom() & 32'h0fff_ffff;
      sg <= g[0];
      xg <= g[0];
      x_drv <= v;
      {dma, mst} <= 2'b11;
      note(1, '1, v);
      note(0, '1, v);
      note(3, '1, g ? v : v & 32'hf0ff_ffff);
      note(6, '1, '1);
      note(7, '1, '0);
      note(4, 32'hc, '0);
      settle();
      v = $urandom() & 32'h0fff_ffff;
      sys_drv <= v;
      dma <= 1'b0;
      note(1, '1, v);
      note(0, '1, v);
      note(2, '1, g ? v : v & 32'hf0ff_ffff);
      settle();
      mst <= 1'b0;
      tick(4);
    end
    $display("dma and master test done");
    a = $urandom() & 32'h00ff_ffff;
    cpu_cycle(a, 1'b0);
    v = $urandom();
    cpu_drv <= ~a;
    x_drv <= v;
    at <= 1'b1;
    note(2, 32'hffff_fffc, a);
    note(7, 32'h3, '0);
    note(3, '1, {a[31:2], v[1:0]});
    note(0, '1, a);
    settle();
    at <= 1'b0;
    $display("at cycle test done");
    summarize();
  end
endmodule
